// ---- hdl/tofrr_i2c_slave.sv ----
// tofrr_i2c_slave: serial bus slave, pointer write and auto-increment block read
module tofrr_i2c_slave (
	input  wire logic      i_clk,
	input  wire logic      i_nrst,
	input  wire logic      i_scl,
	input  wire logic      i_sda,
	output logic           o_sda_oe,
	tofrr_regif_if.slave   bus
);
	import tofrr_pkg::*;

	tofrr_i2c_state_type state;
	tofrr_i2c_state_type next_state;
	logic       scl_q;
	logic       sda_q;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic       rw;
	logic       next_rw;
	logic       first_wr;
	logic       next_first_wr;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic       next_sda_oe;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;

	always_comb begin
		scl_rise      = i_scl & ~scl_q;
		scl_fall      = ~i_scl & scl_q;
		start_cond    = scl_q & i_scl & sda_q & ~i_sda;
		stop_cond     = scl_q & i_scl & ~sda_q & i_sda;
		next_state    = state;
		next_shreg    = shreg;
		next_cnt      = cnt;
		next_rw       = rw;
		next_first_wr = first_wr;
		next_ptr      = ptr;
		next_tx       = tx;
		next_sda_oe   = o_sda_oe;
		if (start_cond) begin
			next_state  = ST_ADDR;
			next_cnt    = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_state  = ST_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				ST_ADDR: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], i_sda};
						next_cnt   = cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						if (shreg[7:1] == DEV_ADDR) begin
							next_rw       = shreg[0];
							next_first_wr = 1'b1;
							next_state    = ST_ACK_ADDR;
							next_sda_oe   = 1'b1;
						end else begin
							next_state = ST_WAIT_STOP;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						next_cnt = 4'h0;
						if (rw) begin
							next_tx     = bus.rdata;
							next_ptr    = ptr + 8'h01;
							next_sda_oe = ~bus.rdata[7];
							next_state  = ST_RD_BYTE;
						end else begin
							next_sda_oe = 1'b0;
							next_state  = ST_WR_BYTE;
						end
					end
				end
				ST_WR_BYTE: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], i_sda};
						next_cnt   = cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						// only the first data byte sets the pointer; the rest are acked and dropped
						if (first_wr) begin
							next_ptr      = shreg;
							next_first_wr = 1'b0;
						end
						next_state  = ST_ACK_WR;
						next_sda_oe = 1'b1;
					end
				end
				ST_ACK_WR: begin
					if (scl_fall) begin
						next_cnt    = 4'h0;
						next_sda_oe = 1'b0;
						next_state  = ST_WR_BYTE;
					end
				end
				ST_RD_BYTE: begin
					if (scl_fall) begin
						if (cnt == 4'h7) begin
							next_sda_oe = 1'b0;
							next_state  = ST_ACK_RD;
						end else begin
							next_tx     = {tx[6:0], 1'b0};
							next_cnt    = cnt + 4'h1;
							next_sda_oe = ~tx[6];
						end
					end
				end
				ST_ACK_RD: begin
					if (scl_rise && i_sda) begin
						next_state = ST_WAIT_STOP;
					end else if (scl_fall) begin
						next_tx     = bus.rdata;
						next_ptr    = ptr + 8'h01;
						next_sda_oe = ~bus.rdata[7];
						next_cnt    = 4'h0;
						next_state  = ST_RD_BYTE;
					end
				end
				default: begin
					next_state = state;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state    <= ST_IDLE;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			shreg    <= RST_BYTE;
			cnt      <= 4'h0;
			rw       <= 1'b0;
			first_wr <= 1'b0;
			ptr      <= RST_BYTE;
			tx       <= RST_BYTE;
			o_sda_oe <= 1'b0;
		end else begin
			state    <= next_state;
			scl_q    <= i_scl;
			sda_q    <= i_sda;
			shreg    <= next_shreg;
			cnt      <= next_cnt;
			rw       <= next_rw;
			first_wr <= next_first_wr;
			ptr      <= next_ptr;
			tx       <= next_tx;
			o_sda_oe <= next_sda_oe;
		end
	end

	assign bus.busy  = (state != ST_IDLE);
	assign bus.start = start_cond;
	assign bus.addr  = ptr;

endmodule : tofrr_i2c_slave

// ---- hdl/tofrr_pkg.sv ----
// tofrr_pkg: constants and types of the time-of-flight result register readout
package tofrr_pkg;

	// register offsets
	localparam logic [7:0] ADDR_FW_MINOR   = 8'h12;
	localparam logic [7:0] ADDR_FW_PATCH   = 8'h13;
	localparam logic [7:0] ADDR_STATUS     = 8'h1D;
	localparam logic [7:0] ADDR_CONTENT    = 8'h1E;
	localparam logic [7:0] ADDR_TID        = 8'h1F;
	localparam logic [7:0] ADDR_RESULT_CNT = 8'h20;
	localparam logic [7:0] ADDR_QUALITY    = 8'h21;
	localparam logic [7:0] ADDR_PEAK_LOW   = 8'h22;
	localparam logic [7:0] ADDR_PEAK_HIGH  = 8'h23;
	localparam logic [7:0] ADDR_TS_BYTE0   = 8'h24;
	localparam logic [7:0] ADDR_TS_BYTE1   = 8'h25;
	localparam logic [7:0] ADDR_TS_BYTE2   = 8'h26;
	localparam logic [7:0] ADDR_TS_BYTE3   = 8'h27;

	// reset values and the value read at unmapped offsets
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [7:0]  UNMAPPED  = 8'h00;

	// general status ranges
	localparam logic [7:0] STATUS_ERR_MIN = 8'h10;

	// content selector codes and the last histogram converter
	localparam logic [7:0] SEL_NONE      = 8'h00;
	localparam logic [7:0] SEL_CALIB     = 8'h0A;
	localparam logic [7:0] SEL_SERIAL    = 8'h47;
	localparam logic [7:0] SEL_RESULTS   = 8'h55;
	localparam logic [7:0] SEL_HIST_BASE = 8'h80;
	localparam logic [2:0] HIST_CONV_MAX = 3'h4;

	// result quality field positions and outcome codes
	localparam int QUAL_REL_LSB     = 0;
	localparam int QUAL_REL_MSB     = 5;
	localparam int QUAL_OUTCOME_LSB = 6;
	localparam int QUAL_OUTCOME_MSB = 7;
	localparam logic [1:0] OUTCOME_NOT_INTERRUPTED = 2'h0;
	localparam logic [1:0] OUTCOME_GPIO_DELAYED    = 2'h2;

	// timestamp step
	localparam int TS_UNIT_NS     = 200;
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TS_TICK_CYCLES = TS_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [5:0] TS_TICK_LAST = 6'(TS_TICK_CYCLES - 1);

	// serial bus device address, value arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;

	typedef enum logic [2:0] {
		CONTENT_NONE,
		CONTENT_CALIB,
		CONTENT_SERIAL,
		CONTENT_RESULTS,
		CONTENT_HISTOGRAM
	} tofrr_content_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_WR_BYTE,
		ST_ACK_WR,
		ST_RD_BYTE,
		ST_ACK_RD,
		ST_WAIT_STOP
	} tofrr_i2c_state_type;

endpackage : tofrr_pkg

// ---- hdl/tofrr_readout.sv ----
// tofrr_readout: result and status register map read by the host over a serial bus
// Overview of operation
// - The general status byte is read-only, with 00h to 0Fh meaning normal and 10h to FFh meaning error.
// - The selector byte reads 0Ah for calibration, 47h for serial number and 55h for detection results.
// - For histogram data the selector reads 80h plus four times the converter plus the quarter, up to 93h.
// - The transaction identifier changes on every update of the register map.
// - The result counter steps by one for every new distinct distance answer.
// - Bits 5:0 of the result quality byte hold reliability from 0 up to the best value 63.
// - With immediate interruption on, bits 7:6 carry the four interrupted or complete outcome codes.
// - With immediate interruption off, bits 7:6 read 0 when not interrupted and 2 when delayed by GPIO.
// - The 16-bit peak distance in millimetres sits low byte at 0x22 and high byte at 0x23.
// - A timestamp counts upward while the clock runs and wraps to zero on overflow.
// - The timestamp is 32 bits in four bytes from 0x24 upward, least significant first, one count per 0.2 us.
module tofrr_readout (
	input  wire logic                        I_CLK_SYS,
	input  wire logic                        I_NRST,
	input  wire logic                        I_SCL,
	input  wire logic                        I_SDA,
	output logic                             O_SDA,
	output logic                             O_SDA_OE,
	input  wire logic [7:0]                  I_FIRMWARE_MINOR_REV,
	input  wire logic [7:0]                  I_FIRMWARE_PATCH_REV,
	input  wire logic [7:0]                  I_STATUS,
	input  wire tofrr_pkg::tofrr_content_type I_CONTENT_KIND,
	input  wire logic [2:0]                  I_HIST_CONVERTER,
	input  wire logic [1:0]                  I_HIST_QUARTER,
	input  wire logic                        I_MAP_UPDATE,
	input  wire logic                        I_NEW_RESULT,
	input  wire logic                        I_IMMEDIATE_INT,
	input  wire logic [1:0]                  I_MEASUREMENT_OUTCOME,
	input  wire logic                        I_GPIO_DELAYED,
	input  wire logic [5:0]                  I_RELIABILITY,
	input  wire logic [15:0]                 I_PEAK_DISTANCE,
	output logic                             O_STATUS_ERROR,
	output logic [31:0]                      O_TIMESTAMP,
	output logic                             O_BUS_BUSY
);
	import tofrr_pkg::*;

	tofrr_regif_if regif ();

	logic [31:0] ts_live;
	logic        ts_tick;
	logic        pending;
	logic        next_pending;
	logic        res_pending;
	logic        next_res_pending;
	logic        apply;
	logic        apply_result;
	logic [7:0]  fw_minor;
	logic [7:0]  next_fw_minor;
	logic [7:0]  fw_patch;
	logic [7:0]  next_fw_patch;
	logic [7:0]  general_status;
	logic [7:0]  next_general_status;
	logic [7:0]  content_sel;
	logic [7:0]  next_content_sel;
	logic [7:0]  tid;
	logic [7:0]  next_tid;
	logic [7:0]  result_counter;
	logic [7:0]  next_result_counter;
	logic [7:0]  result_quality;
	logic [7:0]  next_result_quality;
	logic [15:0] peak_distance;
	logic [15:0] next_peak_distance;
	logic [31:0] ts_snap;
	logic [31:0] next_ts_snap;
	logic [2:0]  conv_clamped;
	logic [1:0]  outcome;

	tofrr_i2c_slave u_slave (
		.i_clk    (I_CLK_SYS),
		.i_nrst   (I_NRST),
		.i_scl    (I_SCL),
		.i_sda    (I_SDA),
		.o_sda_oe (O_SDA_OE),
		.bus      (regif.slave)
	);

	tofrr_timestamp u_timestamp (
		.i_clk   (I_CLK_SYS),
		.i_nrst  (I_NRST),
		.o_count (ts_live),
		.o_tick  (ts_tick)
	);

	// updates wait for the bus to go idle so a block read never sees a mix of old and new
	always_comb begin
		apply            = (pending | I_MAP_UPDATE) & ~regif.busy;
		apply_result     = (res_pending | I_NEW_RESULT) & ~regif.busy;
		next_pending     = (pending | I_MAP_UPDATE | I_NEW_RESULT) & regif.busy;
		next_res_pending = (res_pending | I_NEW_RESULT) & regif.busy;
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_NRST) begin
			pending     <= 1'b0;
			res_pending <= 1'b0;
		end else begin
			pending     <= next_pending;
			res_pending <= next_res_pending;
		end
	end

	// converters above the last one fold onto it rather than produce an undefined code
	always_comb begin
		conv_clamped = (I_HIST_CONVERTER > HIST_CONV_MAX) ? HIST_CONV_MAX : I_HIST_CONVERTER;
		if (I_IMMEDIATE_INT) begin
			outcome = I_MEASUREMENT_OUTCOME;
		end else begin
			outcome = I_GPIO_DELAYED ? OUTCOME_GPIO_DELAYED : OUTCOME_NOT_INTERRUPTED;
		end
	end

	always_comb begin
		next_fw_minor       = fw_minor;
		next_fw_patch       = fw_patch;
		next_general_status = general_status;
		next_content_sel    = content_sel;
		next_tid            = tid;
		next_result_counter = result_counter;
		next_result_quality = result_quality;
		next_peak_distance  = peak_distance;
		next_ts_snap        = ts_snap;
		if (apply || apply_result) begin
			next_fw_minor       = I_FIRMWARE_MINOR_REV;
			next_fw_patch       = I_FIRMWARE_PATCH_REV;
			next_general_status = I_STATUS;
			next_tid            = tid + 8'h01;
			case (I_CONTENT_KIND)
				CONTENT_CALIB:     next_content_sel = SEL_CALIB;
				CONTENT_SERIAL:    next_content_sel = SEL_SERIAL;
				CONTENT_RESULTS:   next_content_sel = SEL_RESULTS;
				CONTENT_HISTOGRAM: next_content_sel = SEL_HIST_BASE + {3'b000, conv_clamped, I_HIST_QUARTER};
				default:           next_content_sel = SEL_NONE;
			endcase
		end
		if (apply_result) begin
			next_result_counter = result_counter + 8'h01;
			next_result_quality[QUAL_REL_MSB:QUAL_REL_LSB]         = I_RELIABILITY;
			next_result_quality[QUAL_OUTCOME_MSB:QUAL_OUTCOME_LSB] = outcome;
			next_peak_distance  = I_PEAK_DISTANCE;
		end
		// timestamp frozen at each transaction start so the four bytes agree
		if (regif.start) begin
			next_ts_snap = ts_live;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_NRST) begin
			fw_minor       <= RST_BYTE;
			fw_patch       <= RST_BYTE;
			general_status <= RST_BYTE;
			content_sel    <= RST_BYTE;
			tid            <= RST_BYTE;
			result_counter <= RST_BYTE;
			result_quality <= RST_BYTE;
			peak_distance  <= {RST_BYTE, RST_BYTE};
			ts_snap        <= RST_WORD;
		end else begin
			fw_minor       <= next_fw_minor;
			fw_patch       <= next_fw_patch;
			general_status <= next_general_status;
			content_sel    <= next_content_sel;
			tid            <= next_tid;
			result_counter <= next_result_counter;
			result_quality <= next_result_quality;
			peak_distance  <= next_peak_distance;
			ts_snap        <= next_ts_snap;
		end
	end

	// read mux; no write path exists into any of these registers
	always_comb begin
		if (regif.addr == ADDR_FW_MINOR) begin
			regif.rdata = fw_minor;
		end else if (regif.addr == ADDR_FW_PATCH) begin
			regif.rdata = fw_patch;
		end else if (regif.addr == ADDR_STATUS) begin
			regif.rdata = general_status;
		end else if (regif.addr == ADDR_CONTENT) begin
			regif.rdata = content_sel;
		end else if (regif.addr == ADDR_TID) begin
			regif.rdata = tid;
		end else if (regif.addr == ADDR_RESULT_CNT) begin
			regif.rdata = result_counter;
		end else if (regif.addr == ADDR_QUALITY) begin
			regif.rdata = result_quality;
		end else if (regif.addr == ADDR_PEAK_LOW) begin
			regif.rdata = peak_distance[7:0];
		end else if (regif.addr == ADDR_PEAK_HIGH) begin
			regif.rdata = peak_distance[15:8];
		end else if (regif.addr == ADDR_TS_BYTE0) begin
			regif.rdata = ts_snap[7:0];
		end else if (regif.addr == ADDR_TS_BYTE1) begin
			regif.rdata = ts_snap[15:8];
		end else if (regif.addr == ADDR_TS_BYTE2) begin
			regif.rdata = ts_snap[23:16];
		end else if (regif.addr == ADDR_TS_BYTE3) begin
			regif.rdata = ts_snap[31:24];
		end else begin
			regif.rdata = UNMAPPED;
		end
	end

	assign O_SDA          = 1'b0;
	assign O_STATUS_ERROR = (general_status >= STATUS_ERR_MIN);
	assign O_TIMESTAMP    = ts_live;
	assign O_BUS_BUSY     = regif.busy;

	sequence s_update_taken;
		apply && !apply_result;
	endsequence

	sequence s_result_taken;
		apply_result;
	endsequence

	property p_status_error;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		s_update_taken |=> (O_STATUS_ERROR == ($past(I_STATUS) >= STATUS_ERR_MIN));
	endproperty
	a_status_error: assert property (p_status_error) else $error("status error flag wrong");

	property p_selector_fixed;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(apply && I_CONTENT_KIND == CONTENT_SERIAL) |=> (content_sel == 8'h47);
	endproperty
	a_selector_fixed: assert property (p_selector_fixed) else $error("serial number selector wrong");

	property p_selector_hist;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		((apply || apply_result) && I_CONTENT_KIND == CONTENT_HISTOGRAM)
			|=> (content_sel >= 8'h80) && (content_sel <= 8'h93);
	endproperty
	a_selector_hist: assert property (p_selector_hist) else $error("histogram selector out of range");

	property p_tid_changes;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(apply || apply_result) |=> (tid != $past(tid));
	endproperty
	a_tid_changes: assert property (p_tid_changes) else $error("transaction id did not change");

	property p_result_count;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		s_result_taken |=> (result_counter == $past(result_counter) + 8'h01)
			&& (peak_distance == $past(I_PEAK_DISTANCE));
	endproperty
	a_result_count: assert property (p_result_count) else $error("result counter or distance not updated");

	property p_reliability;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		s_result_taken |=> (result_quality[5:0] == $past(I_RELIABILITY));
	endproperty
	a_reliability: assert property (p_reliability) else $error("reliability field wrong");

	property p_outcome_imm;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(s_result_taken and I_IMMEDIATE_INT) |=> (result_quality[7:6] == $past(I_MEASUREMENT_OUTCOME));
	endproperty
	a_outcome_imm: assert property (p_outcome_imm) else $error("outcome not passed through");

	property p_outcome_plain;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(s_result_taken and !I_IMMEDIATE_INT)
			|=> (result_quality[7:6] == ($past(I_GPIO_DELAYED) ? 2'h2 : 2'h0));
	endproperty
	a_outcome_plain: assert property (p_outcome_plain) else $error("plain outcome code wrong");

	property p_no_tear;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(regif.busy && !regif.start) |=> $stable(tid) && $stable(ts_snap) && $stable(result_counter);
	endproperty
	a_no_tear: assert property (p_no_tear) else $error("registers changed during a transaction");

	property p_deferred_update;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(regif.busy && (I_MAP_UPDATE || I_NEW_RESULT)) |=> pending && (res_pending || !$past(I_NEW_RESULT));
	endproperty
	a_deferred_update: assert property (p_deferred_update) else $error("update lost during transaction");

	property p_read_only;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		!(apply || apply_result) |=> $stable(general_status) && $stable(result_quality) && $stable(peak_distance);
	endproperty
	a_read_only: assert property (p_read_only) else $error("register changed without update");

	property p_reset_clear;
		@(posedge I_CLK_SYS)
		!I_NRST |=> (tid == RST_BYTE) && (result_counter == RST_BYTE) && (peak_distance == 16'h0000)
			&& (ts_snap == RST_WORD) && !O_SDA_OE;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

	property p_ts_snapshot;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		regif.start |=> (ts_snap == $past(ts_live));
	endproperty
	a_ts_snapshot: assert property (p_ts_snapshot) else $error("timestamp not frozen at start");

	property p_live_step;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		ts_tick |=> (O_TIMESTAMP == $past(O_TIMESTAMP) + 32'h0000_0001);
	endproperty
	a_live_step: assert property (p_live_step) else $error("live timestamp did not step");

endmodule : tofrr_readout

// ---- hdl/tofrr_regif_if.sv ----
// tofrr_regif_if: register read path between serial slave and register file
interface tofrr_regif_if;
	logic       busy;
	logic       start;
	logic [7:0] addr;
	logic [7:0] rdata;

	modport slave (output busy, output start, output addr, input rdata);
	modport regs  (input busy, input start, input addr, output rdata);
endinterface : tofrr_regif_if

// ---- hdl/tofrr_timestamp.sv ----
// tofrr_timestamp: free-running 32-bit timestamp in fixed time steps
module tofrr_timestamp (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	output logic [31:0]      o_count,
	output logic             o_tick
);
	import tofrr_pkg::*;

	localparam int TICK_GAP = TS_TICK_CYCLES;

	logic [5:0]  presc;
	logic [5:0]  next_presc;
	logic [31:0] next_count;

	always_comb begin
		o_tick     = (presc == TS_TICK_LAST);
		next_presc = o_tick ? 6'h00 : presc + 6'h01;
		// wraps to zero on overflow by plain 32-bit arithmetic
		next_count = o_tick ? o_count + 32'h0000_0001 : o_count;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			presc   <= 6'h00;
			o_count <= RST_WORD;
		end else begin
			presc   <= next_presc;
			o_count <= next_count;
		end
	end

	property p_count_step;
		@(posedge i_clk) disable iff (!i_nrst)
		o_tick |=> (o_count == $past(o_count) + 32'h0000_0001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("timestamp did not step on tick");

	property p_tick_gap;
		@(posedge i_clk) disable iff (!i_nrst)
		o_tick |-> ##TICK_GAP o_tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("timestamp step is not 50 cycles");

	property p_hold_between;
		@(posedge i_clk) disable iff (!i_nrst)
		!o_tick |=> $stable(o_count);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("timestamp moved without tick");

endmodule : tofrr_timestamp

// ---- testbench/testbench.sv ----
// testbench: register map scenarios driven through the serial host model
module testbench import tofrr_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk, scl, sda_h, sda_w, sda_oe, sdo, err, busy;
	logic              nrst = 1'b0, mapu = 1'b0, newr = 1'b0, imm = 1'b0, gpio = 1'b0;
	logic [7:0]        minor = 8'h00, patch = 8'h00, stat = 8'h00, tid = 8'h00, cnt = 8'h00;
	tofrr_content_type kind = CONTENT_NONE;
	logic [2:0]        conv = 3'h0;
	logic [1:0]        quar = 2'h0, outc = 2'h0;
	logic [5:0]        rel = 6'h00;
	logic [15:0]       peak = 16'h0000;
	logic [31:0]       ts, ts_tm, ts_out;
	int                n_errors = 0, num_checks = 0, cyc = 0, c0;
	logic [7:0]        sv [4] = '{8'h00, 8'h0F, 8'h10, 8'hFF};
	logic [7:0]        sc [4] = '{SEL_CALIB, SEL_SERIAL, SEL_RESULTS, SEL_NONE};
	tofrr_content_type ks [4] = '{CONTENT_CALIB, CONTENT_SERIAL, CONTENT_RESULTS, CONTENT_NONE};

	// open drain with pull-up; device data pin counts only while enabled
	assign sda_w = sda_h & (sda_oe ? sdo : 1'b1);

	tofrr_readout uut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(sdo),
		.O_SDA_OE(sda_oe), .I_FIRMWARE_MINOR_REV(minor), .I_FIRMWARE_PATCH_REV(patch),
		.I_STATUS(stat), .I_CONTENT_KIND(kind), .I_HIST_CONVERTER(conv), .I_HIST_QUARTER(quar),
		.I_MAP_UPDATE(mapu), .I_NEW_RESULT(newr), .I_IMMEDIATE_INT(imm), .I_MEASUREMENT_OUTCOME(outc),
		.I_GPIO_DELAYED(gpio), .I_RELIABILITY(rel), .I_PEAK_DISTANCE(peak), .O_STATUS_ERROR(err),
		.O_TIMESTAMP(ts_out), .O_BUS_BUSY(busy));
	tofrr_host host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_h));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= nrst ? cyc + 1 : 0;
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic upd(input logic r);
		@(negedge clk);
		{mapu, newr} = {!r, r};
		@(negedge clk);
		{mapu, newr} = 2'h0;
		tid++;
		cnt += 8'(r);
		@(negedge clk);
	endtask : upd

	initial begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		host.rd(ADDR_FW_MINOR, 2);
		chk("revs", 16'h0000, {host.q[1], host.q[0]});
		host.rd(ADDR_STATUS, 12);
		for (int i = 0; i < 7; i++) chk("reg", 8'h00, host.q[i]);
		chk("unmapped", UNMAPPED, host.q[11]);
		$display("test reset done");
		{minor, patch, stat} = {16'hA55A, 8'h0F};
		kind = CONTENT_RESULTS;
		{rel, imm, outc, peak} = {9'h1FF, 16'h1234};
		upd(1'b1);
		host.wr(ADDR_RESULT_CNT, 8'hAA);
		host.rd(ADDR_FW_MINOR, 2);
		chk("revs", 16'hA55A, {host.q[0], host.q[1]});
		c0 = cyc;
		host.rd(ADDR_STATUS, 11);
		chk("status", 8'h0F, host.q[0]);
		chk("sel", SEL_RESULTS, host.q[1]);
		chk("tid", tid, host.q[2]);
		chk("cnt", cnt, host.q[3]);
		chk("quality", 8'hFF, host.q[4]);
		chk("peak", 16'h1234, {host.q[6], host.q[5]});
		ts = {host.q[10], host.q[9], host.q[8], host.q[7]};
		chk("ts_min", 1, ts + 1 >= c0 / 50);
		chk("ts_max", 1, ts <= cyc / 50);
		chk("ts_live", 1, ts <= ts_out);
		$display("test result done");
		for (int i = 0; i < 24; i++) begin
			stat = sv[i % 4];
			kind = i < 4 ? ks[i] : CONTENT_HISTOGRAM;
			conv = 3'((i - 4) / 4);
			quar = 2'(i);
			upd(1'b0);
			host.rd(ADDR_STATUS, 3);
			chk("status", stat, host.q[0]);
			chk("err", stat >= STATUS_ERR_MIN, err);
			chk("sel", i < 4 ? sc[i] : 8'h80 + 8'(i - 4), host.q[1]);
			chk("tid", tid, host.q[2]);
		end
		{conv, quar} = 5'h1F;
		upd(1'b0);
		host.rd(ADDR_CONTENT, 1);
		chk("sel", 8'h93, host.q[0]);
		$display("test selector done");
		for (int j = 0; j < 6; j++) begin
			{imm, gpio, rel} = {j < 4, j == 5, 6'(j)};
			outc = j < 4 ? 2'(j) : 2'h3;
			upd(1'b1);
			host.rd(ADDR_QUALITY, 1);
			chk("quality", {j < 4 ? 2'(j) : (j == 5 ? 2'h2 : 2'h0), 6'(j)}, host.q[0]);
		end
		$display("test outcome done");
		@(negedge clk);
		newr = 1'b1;
		repeat (2) @(negedge clk);
		{mapu, newr} = 2'h2;
		@(negedge clk);
		mapu = 1'b0;
		tid += 8'h03;
		cnt += 8'h02;
		host.rd(ADDR_TID, 9);
		chk("tid", tid, host.q[0]);
		chk("cnt", cnt, host.q[1]);
		ts_tm = {host.q[8], host.q[7], host.q[6], host.q[5]};
		chk("ts_up", 1, ts_tm > ts);
		$display("test back to back done");
		peak = 16'hBEEF;
		fork
			host.rd(ADDR_STATUS, 11);
			begin
				repeat (300) @(negedge clk);
				upd(1'b1);
			end
		join
		chk("tid", tid - 8'h01, host.q[2]);
		chk("peak", 16'h1234, {host.q[6], host.q[5]});
		host.rd(ADDR_PEAK_LOW, 2);
		chk("peak", 16'hBEEF, {host.q[1], host.q[0]});
		$display("test deferred update done");
		host.lv(8'h78);
		host.tx({DEV_ADDR ^ 7'h01, 1'b1});
		chk("ack", 0, host.acked);
		chk("busy", 1, busy);
		host.lv(8'h2F);
		chk("busy", 0, busy);
		$display("test foreign address done");
		end_sim();
	end
endmodule : testbench

// ---- testbench/tofrr_host.sv ----
// tofrr_host: serial bus master model reading the register map
module tofrr_host import tofrr_pkg::*; (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] q [16];
	logic       acked;

	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// quarter of a bit time; device samples every system clock
	task automatic hw();
		repeat (4) @(negedge i_clk);
	endtask : hw

	// steps of {scl, sda}: 8'h78 is a start, 8'h2F a stop
	task automatic lv(input logic [7:0] s);
		for (int k = 7; k > 0; k -= 2) begin
			{o_scl, o_sda} = s[k-:2];
			hw();
		end
	endtask : lv

	task automatic put(input logic b, output logic r);
		o_sda = b;
		hw();
		o_scl = 1'b1;
		hw();
		r = i_sda;
		hw();
		o_scl = 1'b0;
		hw();
	endtask : put

	task automatic tx(input logic [7:0] d);
		logic r;
		for (int k = 7; k >= 0; k--) put(d[k], r);
		put(1'b1, r);
		acked = !r;
	endtask : tx

	task automatic rd(input logic [7:0] p, input int n);
		logic r;
		lv(8'h78);
		tx({DEV_ADDR, 1'b0});
		tx(p);
		lv(8'h78);
		tx({DEV_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			for (int k = 7; k >= 0; k--) put(1'b1, q[i][k]);
			put(i == n - 1, r);
		end
		lv(8'h2F);
	endtask : rd

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		lv(8'h78);
		tx({DEV_ADDR, 1'b0});
		tx(p);
		tx(d);
		lv(8'h2F);
	endtask : wr
endmodule : tofrr_host
